/* File: usbs_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RQ1: Per-endpoint done enables raise interrupt; endpoint 0 enable covers both flags.
// RQ2: Resume request drives K only when suspended with remote wakeup allowed.
// RQ3: Forced resume is held for longer than 3 ms.
// RQ4: Configured bit reads 1 only for configuration one.
// RQ5: Setup flag sets on valid request packets without bus errors.
// RQ6: Status and endpoint 0 done flags clear on written zero.
// RQ7: Start-of-frame flag sets on each detected frame start.
// RQ8: Configuration change flag sets when a new configuration is accepted.
// RQ9: Bus reset sets flag; resets MCU unless redirected to interrupt.
// RQ10: Wake flag sets on bus activity during suspend.
// RQ11: Sleep flag sets on suspend state or 3 ms idle; enters suspend.
// RQ12: Software should gate the USB clock before stop mode.
// RQ13: Protocol halt stalls endpoint 0 tokens until next SETUP.
// RQ14: Each status flag has its own interrupt mask bit.
// RQ15: Bus reset interrupt needs flag, mask and redirect all set.
// RQ16: Endpoint 0 receive count holds size of last valid OUT.
// RQ17: Software writes transmit count before arming transmission.
// RQ18: Tx armed bit clears on good IN, valid SETUP or zero.
// RQ19: IN tokens are NAKed while tx armed bit is zero.
// RQ20: Tx done flag sets after IN completes; NAKs IN while set.
// RQ21: Rx full sets on stored data; software clears; NAK meanwhile.
// RQ22: Rx done sets on stored OUT or SETUP; NAKs OUT while set.
// RQ23: Eight data bytes read receive buffer and write transmit buffer.
// RQ24: Interrupt line is OR of every enabled flag.
module usbs_ctrl
    import usbs_pkg::*;
#(
    parameter int RESUME_CYC = USBS_RESUME_CYC,
    parameter int IDLE_CYC = USBS_IDLE_CYC
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic srst_in,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Bus events from the serial engine, one-cycle pulses
    input wire logic setup_req_in,
    input wire logic pkt_err_in,
    input wire logic sof_in,
    input wire logic cfg_set_in,
    input wire logic [7:0] cfg_value_in,
    input wire logic bus_reset_in,
    input wire logic bus_activity_in,
    input wire logic suspend_state_in,
    // Bus levels
    input wire logic bus_idle_in,
    input wire logic remote_wake_en_in,
    // Endpoint 0 traffic from the serial engine
    input wire logic tok_in_in,
    input wire logic tok_out_in,
    input wire logic in_ack_in,
    input wire logic setup_stored_in,
    input wire logic out_stored_in,
    input wire logic [3:0] out_count_in,
    input wire logic rx_wr_in,
    input wire logic [2:0] rx_addr_in,
    input wire logic [7:0] rx_data_in,
    input wire logic [2:0] tx_addr_in,
    // Done flags of endpoints 1 to 4, levels
    input wire logic [3:0] xfer_done_flag_in,
    // Endpoint 0 answers
    output logic [1:0] ep0_in_hs_out,
    output logic [1:0] ep0_out_hs_out,
    output logic [7:0] tx_data_out,
    output logic [3:0] ep_zero_tx_count_out,
    // Bus drive and system
    output logic force_k_out,
    output logic usb_clock_gate_out,
    output logic usb_module_enable_out,
    output logic mcu_reset_out,
    output logic irq_out
);
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] rd_d;
    logic hit_d;
    logic wr_en;
    logic [7:0] wr_byte;
    logic [7:0] ctrl_q;
    logic [6:0] flags_q;
    logic [6:0] mask_q;
    logic halt_q;
    logic [4:0] xie_q;
    logic [3:0] rx_count_q;
    logic [3:0] tx_count_q;
    logic tx_armed_q;
    logic tx_done_q;
    logic rx_full_q;
    logic rx_done_q;
    logic configured_q;
    logic suspended_q;
    logic [7:0] rx_buf [USBS_NBYTES];
    logic [7:0] tx_buf [USBS_NBYTES];
    logic [7:0] tx_data_q;
    logic [1:0] in_hs_q;
    logic [1:0] out_hs_q;
    usbs_rs_e rs_q;
    logic [31:0] rs_cnt_q;
    logic [31:0] idle_cnt_q;
    logic idle_hit;
    logic force_k_q;
    logic mcu_rst_q;
    logic irq_q;
    logic [6:0] flag_set;
    logic [4:0] done_vec;

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign tx_data_out = tx_data_q;
    assign ep_zero_tx_count_out = tx_count_q;
    assign ep0_in_hs_out = in_hs_q;
    assign ep0_out_hs_out = out_hs_q;
    assign force_k_out = force_k_q;
    assign usb_clock_gate_out = ctrl_q[CR_CLK_GATE];
    assign usb_module_enable_out = ctrl_q[CR_MOD_EN];
    assign mcu_reset_out = mcu_rst_q;
    assign irq_out = irq_q;

    // A write takes effect only at the edge where pready is sampled high
    assign wr_en = psel && penable && pwrite && pready_q && hit_d;
    assign wr_byte = pwdata[7:0];

    always_comb begin
        rd_d = '0;
        hit_d = 1'b1;
        if (paddr >= USBS_OFF_DATA &&
            paddr < USBS_OFF_DATA + 8'(4 * USBS_NBYTES) &&
            paddr[1:0] == 2'b00) begin
            rd_d[7:0] = rx_buf[paddr[4:2]]; // see RQ23
        end else begin
            unique case (paddr)
                USBS_OFF_CTRL: begin
                    // Resume request is write-only and reads zero
                    rd_d[7:0] = {ctrl_q[7:1], 1'b0}; // see RQ2
                end
                USBS_OFF_STAT: begin
                    rd_d[6:0] = {flags_q[6:1], configured_q}; // see RQ4
                end
                USBS_OFF_MASK: begin
                    rd_d[6:0] = {mask_q[6:1], 1'b0}; // see RQ13
                end
                USBS_OFF_EP0: begin
                    rd_d[EP_RXCNT_LSB +: 4] = rx_count_q; // see RQ16
                    rd_d[EP_TX_ARMED] = tx_armed_q;
                    rd_d[EP_TX_DONE] = tx_done_q;
                    rd_d[EP_RX_FULL] = rx_full_q;
                    rd_d[EP_RX_DONE] = rx_done_q;
                end
                USBS_OFF_XIE: begin
                    rd_d[4:0] = xie_q;
                end
                default: begin
                    hit_d = 1'b0;
                end
            endcase
        end
    end

    // One wait state: answer is registered so pready comes from a flop
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            pready_q <= 1'b0;
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end else if (psel && penable && !pready_q) begin
            pready_q <= 1'b1;
            prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
            pslverr_q <= !hit_d;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            ctrl_q <= USBS_RST_BYTE;
            mask_q <= '0;
            xie_q <= USBS_RST_XIE;
        end else if (wr_en && paddr == USBS_OFF_CTRL) begin
            ctrl_q <= {wr_byte[7:1], 1'b0};
        end else if (wr_en && paddr == USBS_OFF_MASK) begin
            mask_q <= {wr_byte[6:1], 1'b0}; // see RQ14
        end else if (wr_en && paddr == USBS_OFF_XIE) begin
            xie_q <= wr_byte[4:0]; // see RQ1
        end
    end

    // Buffers are not reset, like the RAM behind them
    always_ff @(posedge clk_sys_in) begin
        if (rx_wr_in) begin
            rx_buf[rx_addr_in] <= rx_data_in;
        end
        if (wr_en && paddr >= USBS_OFF_DATA) begin
            tx_buf[paddr[4:2]] <= wr_byte; // see RQ23
        end
        tx_data_q <= tx_buf[tx_addr_in];
    end

    // Hardware event sources of the status flags
    always_comb begin
        flag_set = '0;
        flag_set[SR_SETUP] = setup_req_in && !pkt_err_in; // see RQ5
        flag_set[SR_SOF] = sof_in; // see RQ7
        flag_set[SR_CFG_CHG] = cfg_set_in &&
            cfg_value_in <= USBS_CFG_ONE; // see RQ8
        flag_set[SR_BUS_RST] = bus_reset_in; // see RQ9
        flag_set[SR_WAKE] = bus_activity_in && suspended_q; // see RQ10
        flag_set[SR_SLEEP] = suspend_state_in || idle_hit; // see RQ11
    end

    // Set wins over a clear written in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_flag
            always_ff @(posedge clk_sys_in) begin
                if (srst_in) begin
                    flags_q[gi] <= 1'b0;
                end else if (flag_set[gi]) begin
                    flags_q[gi] <= 1'b1;
                end else if (wr_en && paddr == USBS_OFF_STAT &&
                             !wr_byte[gi]) begin
                    flags_q[gi] <= 1'b0; // see RQ6
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            configured_q <= 1'b0;
        end else if (cfg_set_in && cfg_value_in <= USBS_CFG_ONE) begin
            configured_q <= cfg_value_in == USBS_CFG_ONE; // see RQ4
        end
    end

    // Idle timer for the suspend detection
    assign idle_hit = idle_cnt_q == 32'(IDLE_CYC - 1);
    always_ff @(posedge clk_sys_in) begin
        if (srst_in || !bus_idle_in || suspended_q) begin
            idle_cnt_q <= '0;
        end else if (!idle_hit) begin
            idle_cnt_q <= idle_cnt_q + 32'd1; // see RQ11
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            suspended_q <= 1'b0;
        end else if (flag_set[SR_SLEEP]) begin
            suspended_q <= 1'b1; // see RQ11
        end else if (bus_activity_in || bus_reset_in ||
                     (rs_q == RS_DRIVE && rs_cnt_q == '0)) begin
            suspended_q <= 1'b0;
        end
    end

    // Remote wakeup: drive K for the whole resume time, then leave suspend
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            rs_q <= RS_IDLE;
            rs_cnt_q <= '0;
            force_k_q <= 1'b0;
        end else begin
            unique case (rs_q)
                RS_IDLE: begin
                    if (wr_en && paddr == USBS_OFF_CTRL &&
                        wr_byte[CR_RESUME] && suspended_q &&
                        remote_wake_en_in) begin
                        rs_q <= RS_DRIVE; // see RQ2
                        rs_cnt_q <= 32'(RESUME_CYC - 1);
                        force_k_q <= 1'b1;
                    end
                end
                RS_DRIVE: begin
                    if (rs_cnt_q == '0) begin
                        rs_q <= RS_IDLE;
                        force_k_q <= 1'b0;
                    end else begin
                        rs_cnt_q <= rs_cnt_q - 32'd1; // see RQ3
                    end
                end
            endcase
        end
    end

    // Protocol halt: set by software, cleared only by a SETUP or reset
    always_ff @(posedge clk_sys_in) begin
        if (srst_in || setup_stored_in) begin
            halt_q <= 1'b0;
        end else if (wr_en && paddr == USBS_OFF_MASK && wr_byte[MR_HALT]) begin
            halt_q <= 1'b1; // see RQ13
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            tx_count_q <= USBS_RST_CNT;
            rx_count_q <= USBS_RST_CNT;
        end else begin
            if (wr_en && paddr == USBS_OFF_EP0) begin
                tx_count_q <= wr_byte[EP_TXCNT_LSB +: 4]; // see RQ17
            end
            if (out_stored_in) begin
                rx_count_q <= out_count_in; // see RQ16
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in || in_ack_in || setup_stored_in) begin
            tx_armed_q <= 1'b0; // see RQ18
        end else if (wr_en && paddr == USBS_OFF_EP0) begin
            tx_armed_q <= pwdata[EP_TX_ARMED];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            tx_done_q <= 1'b0;
            rx_full_q <= 1'b0;
            rx_done_q <= 1'b0;
        end else begin
            if (in_ack_in) begin
                tx_done_q <= 1'b1; // see RQ20
            end else if (wr_en && paddr == USBS_OFF_EP0 &&
                         !pwdata[EP_TX_DONE]) begin
                tx_done_q <= 1'b0; // see RQ6
            end
            if (out_stored_in || setup_stored_in) begin
                rx_full_q <= 1'b1; // see RQ21
                rx_done_q <= 1'b1; // see RQ22
            end else if (wr_en && paddr == USBS_OFF_EP0) begin
                if (!pwdata[EP_RX_FULL]) begin
                    rx_full_q <= 1'b0;
                end
                if (!pwdata[EP_RX_DONE]) begin
                    rx_done_q <= 1'b0; // see RQ6
                end
            end
        end
    end

    // Handshake answer, valid one cycle after the token pulse
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            in_hs_q <= HS_NONE;
            out_hs_q <= HS_NONE;
        end else begin
            in_hs_q <= HS_NONE;
            out_hs_q <= HS_NONE;
            if (tok_in_in) begin
                if (halt_q) begin
                    in_hs_q <= HS_STALL; // see RQ13
                end else if (!tx_armed_q || tx_done_q) begin
                    in_hs_q <= HS_NAK; // see RQ19 see RQ20
                end else begin
                    in_hs_q <= HS_ACK;
                end
            end
            if (tok_out_in) begin
                if (halt_q) begin
                    out_hs_q <= HS_STALL; // see RQ13
                end else if (rx_full_q || rx_done_q) begin
                    out_hs_q <= HS_NAK; // see RQ21 see RQ22
                end else begin
                    out_hs_q <= HS_ACK;
                end
            end
        end
    end

    // Without redirect a bus reset restarts the whole MCU
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            mcu_rst_q <= 1'b0;
        end else begin
            mcu_rst_q <= bus_reset_in && !ctrl_q[CR_REDIRECT]; // see RQ9
        end
    end

    assign done_vec = {xfer_done_flag_in, tx_done_q || rx_done_q}; // see RQ1
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(done_vec & xie_q) ||
                |(flags_q[6:1] & mask_q[6:1] & 6'b11_0111) ||
                (flags_q[SR_BUS_RST] && mask_q[SR_BUS_RST] &&
                 ctrl_q[CR_REDIRECT]); // see RQ14 see RQ15 see RQ24
        end
    end
endmodule
`default_nettype wire

/* File: usbs_ctrl_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module usbs_ctrl_properties
    import usbs_pkg::*;
#(
    parameter int RESUME_CYC = USBS_RESUME_CYC
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic srst_in,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // Bus events
    input wire logic setup_req_in,
    input wire logic sof_in,
    input wire logic cfg_set_in,
    input wire logic bus_reset_in,
    input wire logic bus_activity_in,
    input wire logic suspend_state_in,
    input wire logic bus_idle_in,
    input wire logic remote_wake_en_in,
    input wire logic tok_in_in,
    input wire logic tok_out_in,
    input wire logic in_ack_in,
    input wire logic setup_stored_in,
    input wire logic out_stored_in,
    input wire logic [3:0] xfer_done_flag_in,
    // Answers
    input wire logic [1:0] ep0_in_hs_out,
    input wire logic [1:0] ep0_out_hs_out,
    input wire logic force_k_out,
    input wire logic mcu_reset_out,
    input wire logic irq_out
);
    default clocking @(posedge clk_sys_in);
    endclocking
    default disable iff (srst_in);
    logic take;
    logic cause;
    logic [31:0] k_cnt_q;
    logic halt_seen_q;
    assign take = psel && penable && pready;
    // Anything that can set a flag or an enable
    assign cause = take || setup_req_in || sof_in || cfg_set_in
        || bus_reset_in || bus_activity_in || suspend_state_in
        || bus_idle_in || in_ack_in || setup_stored_in || out_stored_in
        || (xfer_done_flag_in != 4'h0);
    // Counted so that a K state one cycle short is caught
    always_ff @(posedge clk_sys_in) begin
        if (srst_in || !force_k_out)
            k_cnt_q <= 32'h0000_0000;
        else
            k_cnt_q <= k_cnt_q + 32'h0000_0001;
    end
    // Halt requested by software and not yet ended by a SETUP
    always_ff @(posedge clk_sys_in) begin
        if (srst_in || setup_stored_in) begin
            halt_seen_q <= 1'b0;
        end else if (take && pwrite && paddr == USBS_OFF_MASK &&
                     pwdata[MR_HALT]) begin
            halt_seen_q <= 1'b1;
        end
    end
    a_resume_long: assert property ($fell(force_k_out) |->
        k_cnt_q == RESUME_CYC) else $error("K length wrong");
    a_resume_gate: assert property ($rose(force_k_out) |->
        $past(take && pwrite && paddr == USBS_OFF_CTRL
        && pwdata[CR_RESUME] && remote_wake_en_in))
        else $error("K without request");
    a_reset_pulse: assert property (mcu_reset_out |->
        $past(bus_reset_in)) else $error("system reset without cause");
    a_in_answer: assert property (tok_in_in |=>
        ep0_in_hs_out != HS_NONE) else $error("IN token unanswered");
    a_out_answer: assert property (tok_out_in |=>
        ep0_out_hs_out != HS_NONE) else $error("OUT token unanswered");
    a_halt_stall: assert property (halt_seen_q && tok_in_in
        |=> ep0_in_hs_out == HS_STALL) else $error("no stall");
    a_apb_answer: assert property (psel && penable && !pready
        |=> pready) else $error("APB answer late");
    a_irq_cause: assert property ($rose(irq_out) |->
        $past(cause) || $past(cause, 2)) else $error("irq without cause");
endmodule
bind usbs_ctrl usbs_ctrl_properties #(.RESUME_CYC(RESUME_CYC)) u_props (.*);
`default_nettype wire

/* File: usbs_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module usbs_ctrl_tb
    import usbs_pkg::*;
();
    localparam int RES_CYC = 20;
    logic clk_sys_in = 1'b0, srst_in = 1'b1, rerr;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [7:0] paddr = 8'h00, val, tx_data_out;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
    logic pkt_err_in = 1'b0, bus_idle_in = 1'b0, remote_wake_en_in = 1'b0;
    logic [2:0] rx_addr_in = 3'h0, tx_addr_in = 3'h0;
    logic [3:0] xfer_done_flag_in = 4'h0, ep_zero_tx_count_out, cnt;
    logic [1:0] ep0_in_hs_out, ep0_out_hs_out;
    logic force_k_out, usb_clock_gate_out, usb_module_enable_out;
    logic mcu_reset_out, irq_out;
    logic [11:0] ev;
    logic [7:0] dat [8];
    int fail_count = 0, checks_done = 0, i, n;
    int ord [6] = '{0, 1, 3, 5, 4, 2};
    usbs_host_model host (.clk_in(clk_sys_in), .ev_out(ev), .val_out(val));
    usbs_ctrl #(.RESUME_CYC(RES_CYC), .IDLE_CYC(30)) DUT (
        .*,
        .setup_req_in(ev[0]), .sof_in(ev[1]), .cfg_set_in(ev[2]),
        .bus_reset_in(ev[3]), .bus_activity_in(ev[4]),
        .suspend_state_in(ev[5]), .tok_in_in(ev[6]), .tok_out_in(ev[7]),
        .in_ack_in(ev[8]), .setup_stored_in(ev[9]), .out_stored_in(ev[10]),
        .rx_wr_in(ev[11]), .cfg_value_in(val), .out_count_in(val[3:0]),
        .rx_data_in(val)
    );
    always #4 clk_sys_in = ~clk_sys_in;
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys_in);
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One idle edge after each transfer keeps psel from two writes at once
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_in);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys_in);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, rdat, e);
    endtask
    task automatic irq_is(input logic e);
        tick(2);
        chk("irq", 32'(irq_out), 32'(e));
    endtask
    task automatic tok(input int k, input logic [1:0] e);
        host.fire(k, 8'h00);
        tick(1);
        chk("handshake", 32'(k == 6 ? ep0_in_hs_out : ep0_out_hs_out), 32'(e));
    endtask
    // Event k sets status bit k+1; config one also sets the configured bit
    function automatic logic [31:0] flag_exp(input int k);
        return (32'h0000_0001 << (k + 1)) | 32'(k == 2);
    endfunction
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        fail_count++;
        finish_test();
    end
    initial begin
        n = $urandom(32'h956d_e13c);
        tick(2);
        srst_in <= 1'b0;
        for (i = 0; i < 5; i++)
            rd("reset value", 8'(4 * i), 32'h0000_0000);
        apb(1'b0, 8'h14, 32'h0000_0000);
        chk("unmapped", 32'(rerr), 32'h0000_0001);
        $display("registers test done");
        host.fire(3, 8'h00);
        tick(1);
        chk("system reset", 32'(mcu_reset_out), 32'h0000_0001);
        wr(USBS_OFF_STAT, 32'h0000_0000);
        pkt_err_in <= 1'b1;
        host.fire(0, 8'h00);
        pkt_err_in <= 1'b0;
        tick(1);
        host.fire(4, 8'h00);
        tick(1);
        host.fire(2, 8'($urandom_range(255, 2)));
        rd("no flag", USBS_OFF_STAT, 32'h0000_0000);
        wr(USBS_OFF_CTRL, 32'h0000_0002);
        for (i = 0; i < 6; i++) begin
            host.fire(ord[i], 8'h01);
            rd("flag", USBS_OFF_STAT,
               flag_exp(ord[i]));
            wr(USBS_OFF_MASK, flag_exp(ord[i]) & 32'h0000_007e);
            irq_is(1'b1);
            wr(USBS_OFF_STAT, 32'h0000_00ff);
            irq_is(1'b1);
            wr(USBS_OFF_STAT, 32'h0000_0000);
            irq_is(1'b0);
        end
        $display("status test done");
        remote_wake_en_in <= 1'b1;
        wr(USBS_OFF_CTRL, 32'h0000_000f);
        rd("control", USBS_OFF_CTRL, 32'h0000_000e);
        chk("control pins", 32'({usb_module_enable_out,
            usb_clock_gate_out}), 32'h0000_0003);
        chk("K awake", 32'(force_k_out), 32'h0000_0000);
        bus_idle_in <= 1'b1;
        tick(25);
        rd("idle short", USBS_OFF_STAT, 32'h0000_0001);
        tick(5);
        rd("idle long", USBS_OFF_STAT, 32'h0000_0041);
        bus_idle_in <= 1'b0;
        remote_wake_en_in <= 1'b0;
        wr(USBS_OFF_CTRL, 32'h0000_000f);
        tick(1);
        chk("K gated", 32'(force_k_out), 32'h0000_0000);
        remote_wake_en_in <= 1'b1;
        wr(USBS_OFF_CTRL, 32'h0000_000f);
        n = 0;
        while (force_k_out !== 1'b1 && n < 4) begin
            tick(1);
            n++;
        end
        n = 0;
        while (force_k_out === 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        chk("K length", n, RES_CYC);
        $display("resume test done");
        for (i = 0; i < 8; i++) begin
            dat[i] = 8'($urandom);
            wr(8'(USBS_OFF_DATA + 4 * i), 32'(dat[i]));
        end
        for (i = 0; i < 8; i++) begin
            tx_addr_in <= 3'(i);
            tick(2);
            chk("tx byte", 32'(tx_data_out), 32'(dat[i]));
            dat[i] = 8'($urandom);
            rx_addr_in <= 3'(i);
            host.fire(11, dat[i]);
            rd("rx byte", 8'(USBS_OFF_DATA + 4 * i), 32'(dat[i]));
        end
        tok(6, HS_NAK);
        tok(7, HS_ACK);
        wr(USBS_OFF_EP0, 32'h0000_0050);
        wr(USBS_OFF_EP0, 32'h0000_0150);
        chk("tx count", 32'(ep_zero_tx_count_out), 32'h0000_0005);
        tok(6, HS_ACK);
        host.fire(8, 8'h00);
        rd("tx done", USBS_OFF_EP0, 32'h0000_0200);
        wr(USBS_OFF_XIE, 32'h0000_0001);
        irq_is(1'b1);
        wr(USBS_OFF_EP0, 32'h0000_0300);
        tok(6, HS_NAK);
        cnt = 4'($urandom_range(8, 1));
        host.fire(10, 8'(cnt));
        rd("rx done", USBS_OFF_EP0, 32'h0000_0f00 | 32'(cnt));
        tok(7, HS_NAK);
        wr(USBS_OFF_EP0, 32'h0000_0000);
        irq_is(1'b0);
        rd("ep0 clear", USBS_OFF_EP0, 32'(cnt));
        wr(USBS_OFF_MASK, 32'h0000_0001);
        rd("halt", USBS_OFF_MASK, 32'h0000_0000);
        tok(7, HS_STALL);
        wr(USBS_OFF_MASK, 32'h0000_0000);
        tok(6, HS_STALL);
        wr(USBS_OFF_EP0, 32'h0000_0100);
        host.fire(9, 8'h00);
        tick(1);
        tok(6, HS_NAK);
        apb(1'b0, USBS_OFF_EP0, 32'h0000_0000);
        chk("setup", rdat & 32'h0000_0900, 32'h0000_0800);
        $display("endpoint test done");
        xfer_done_flag_in <= 4'($urandom_range(15, 1));
        wr(USBS_OFF_EP0, 32'h0000_0000);
        wr(USBS_OFF_XIE, 32'h0000_0000);
        irq_is(1'b0);
        wr(USBS_OFF_XIE, 32'(xfer_done_flag_in) << 1);
        irq_is(1'b1);
        wr(USBS_OFF_CTRL, 32'h0000_0000);
        chk("clock gate", 32'(usb_clock_gate_out), 32'h0000_0000);
        $display("interrupt test done");
        finish_test();
    end
endmodule
`default_nettype wire

/* File: usbs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host side of endpoint 0: serial engine events, one cycle wide
module usbs_host_model (
    // Clock
    input wire logic clk_in,
    // Events and the byte that goes with them
    output logic [11:0] ev_out,
    output logic [7:0] val_out
);
    initial begin
        ev_out = 12'h000;
        val_out = 8'h00;
    end
    // Raised just after an edge, dropped after the next one
    task automatic fire(input int idx, input logic [7:0] v);
        ev_out[idx] <= 1'b1;
        val_out <= v;
        @(posedge clk_in);
        ev_out <= 12'h000;
    endtask
endmodule
`default_nettype wire

/* File: usbs_pkg.sv */
package usbs_pkg;
    // Register byte offsets
    localparam logic [7:0] USBS_OFF_CTRL = 8'h00;
    localparam logic [7:0] USBS_OFF_STAT = 8'h04;
    localparam logic [7:0] USBS_OFF_MASK = 8'h08;
    localparam logic [7:0] USBS_OFF_EP0 = 8'h0C;
    localparam logic [7:0] USBS_OFF_XIE = 8'h10;
    localparam logic [7:0] USBS_OFF_DATA = 8'h20;
    localparam int USBS_NBYTES = 8;
    // usb_control fields
    localparam int CR_RESUME = 0;
    localparam int CR_REDIRECT = 1;
    localparam int CR_CLK_GATE = 2;
    localparam int CR_MOD_EN = 3;
    // usb_status_flags fields; bits 1 to 6 keep their positions in the mask register, whose bit 0 is MR_HALT
    localparam int SR_CONFIGURED = 0;
    localparam int SR_SETUP = 1;
    localparam int SR_SOF = 2;
    localparam int SR_CFG_CHG = 3;
    localparam int SR_BUS_RST = 4;
    localparam int SR_WAKE = 5;
    localparam int SR_SLEEP = 6;
    localparam int MR_HALT = 0;
    // ep0_control_status fields
    localparam int EP_RXCNT_LSB = 0;
    localparam int EP_TXCNT_LSB = 4;
    localparam int EP_TX_ARMED = 8;
    localparam int EP_TX_DONE = 9;
    localparam int EP_RX_FULL = 10;
    localparam int EP_RX_DONE = 11;
    localparam int USBS_NEP = 5;
    // Reset values
    localparam logic [7:0] USBS_RST_BYTE = 8'h00;
    localparam logic [3:0] USBS_RST_CNT = 4'h0;
    localparam logic [4:0] USBS_RST_XIE = 5'h00;
    // Handshake answers
    localparam logic [1:0] HS_NONE = 2'h0;
    localparam logic [1:0] HS_ACK = 2'h1;
    localparam logic [1:0] HS_NAK = 2'h2;
    localparam logic [1:0] HS_STALL = 2'h3;
    localparam logic [7:0] USBS_CFG_ONE = 8'h01;
    // Timing
    localparam int USBS_CLK_MHZ = 125;
    localparam int USBS_T_RESUME_US = 3000;
    localparam int USBS_T_IDLE_US = 3000;
    // Resume must exceed 3 ms: one cycle more than the exact count
    localparam int USBS_RESUME_CYC = USBS_T_RESUME_US * USBS_CLK_MHZ + 1;
    localparam int USBS_IDLE_CYC = USBS_T_IDLE_US * USBS_CLK_MHZ;
    typedef enum logic {RS_IDLE, RS_DRIVE} usbs_rs_e;
endpackage
